/* dv/blpmd_dram_model.sv */
`timescale 1ns/1ns
module blpmd_dram_model #(
   parameter int ACC_NS = 20
) (
   input wire blpmd_pkg::blpmd_pins_type pins,
   input wire logic [15:0] dq_bus,
   output logic [15:0] dq_drv,
   output logic [1:0] dq_en,
   output int cbr_cnt,
   output int bad_cnt,
   output int max_gap_ns,
   output int self_low_ns
);
   logic [15:0] mem [logic [19:0]];
   logic [9:0] row = 10'h000;
   logic [9:0] col = 10'h000;
   logic [9:0] rcnt = 10'h000;
   logic column_before_row_refresh = 1'b0;
   logic [15:0] rd_word = 16'h0000;
   logic cas_n;
   time t_fall = 0;
   time t_rise = 0;
   time t_cbr = 0;
   initial begin
      cbr_cnt = 0;
      bad_cnt = 0;
      max_gap_ns = 0;
      self_low_ns = 0;
   end
   assign cas_n = pins.col_lo_n & pins.col_hi_n;
   // output turns on one access time late, so a sample taken too early sees the released pattern
   assign #(ACC_NS) dq_en = {~pins.col_hi_n, ~pins.col_lo_n} & {2{~pins.row_n & ~pins.oe_n & pins.write_n & ~column_before_row_refresh}};
   assign dq_drv = rd_word;
   task automatic store();
      logic [15:0] w;
      // the strobe and the bus drivers switch in one time step; take data once the bus has settled
      #1;
      w = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
      if (!pins.col_lo_n) w[7:0] = dq_bus[7:0];
      if (!pins.col_hi_n) w[15:8] = dq_bus[15:8];
      mem[{row, col}] = w;
   endtask
   always @(negedge pins.row_n) begin
      column_before_row_refresh = ~cas_n;
      if (column_before_row_refresh) begin
         cbr_cnt++;
         if (!pins.write_n) bad_cnt++;
         if (cbr_cnt > 1 && int'($time - t_cbr) > max_gap_ns) max_gap_ns = int'($time - t_cbr);
         row = rcnt;
         rcnt = rcnt + 10'h001;
      end else begin
         row = pins.addr;
      end
      if ($time - t_rise < blpmd_pkg::TRC_NS) bad_cnt++;
      t_fall = $time;
   end
   always @(posedge pins.row_n) begin
      if (column_before_row_refresh && int'($time - t_fall) > self_low_ns) self_low_ns = int'($time - t_fall);
      if (column_before_row_refresh) t_cbr = $time;
      t_rise = $time;
      column_before_row_refresh = 1'b0;
   end
   always @(negedge cas_n) begin
      if (!pins.row_n && !column_before_row_refresh) begin
         col = pins.addr;
         rd_word = mem.exists({row, col}) ? mem[{row, col}] : 16'h0000;
         if (!pins.write_n) store();
      end
   end
   always @(negedge pins.write_n) begin
      if (!pins.row_n && !cas_n && !column_before_row_refresh) store();
   end
   always @(pins.dq_oe, dq_en) begin
      if (|(pins.dq_oe & dq_en)) bad_cnt++;
   end
endmodule // blpmd_dram_model

/* dv/byte_lane_page_mode_dram_tb.sv */
`timescale 1ns/1ns
module byte_lane_page_mode_dram_tb;
   localparam int REFI = 200;
   localparam int SELF = 30;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic self_req = 1'b0;
   blpmd_pkg::blpmd_req_type req = '0;
   logic req_ready, rdata_valid, in_self, init_done;
   logic [15:0] rdata, dq_in, dq_drv;
   logic [15:0] float_v = 16'hA5C3;
   logic [1:0] dq_en;
   blpmd_pkg::blpmd_pins_type pins;
   int cbr_cnt, bad_cnt, max_gap_ns, self_low_ns;
   int miscompares = 0;
   int comparisons = 0;
   logic [31:0] expq [$];
   logic [15:0] ref_mem [logic [19:0]];
   logic [19:0] addrs [16];
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   // released lanes toggle every cycle so a stale value cannot pass
   always @(posedge sys_clk) float_v <= ~float_v;
   for (genvar i = 0; i < 2; i++) begin : g_lane
      assign dq_in[8*i+:8] = pins.dq_oe[i] ? pins.dq_out[8*i+:8] : dq_en[i] ? dq_drv[8*i+:8] : float_v[8*i+:8];
   end
   blpmd_ctrl #(.REFI_CYC(REFI), .PWRUP_CYC(20), .SELF_CYC(SELF)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .req(req), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .self_req(self_req),
      .in_self(in_self), .init_done(init_done), .pins(pins), .dq_in(dq_in));
   blpmd_dram_model #(.ACC_NS(20)) model (.pins(pins), .dq_bus(dq_in), .dq_drv(dq_drv), .dq_en(dq_en),
      .cbr_cnt(cbr_cnt), .bad_cnt(bad_cnt), .max_gap_ns(max_gap_ns), .self_low_ns(self_low_ns));
   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic timeout();
      miscompares++;
      finish_test();
   endtask
   task automatic access(input logic wr, input logic [1:0] be, input logic [19:0] a, input logic [15:0] d,
                         input logic lst);
      int n;
      logic [15:0] m;
      m = {{8{be[1]}}, {8{be[0]}}};
      @(negedge sys_clk);
      req = '{valid: 1'b1, write: wr, byte_en: be, addr: a, wdata: d, last: lst};
      #1;
      for (n = 0; n < 500 && req_ready !== 1'b1; n++) begin
         @(negedge sys_clk);
         #1;
      end
      if (n == 500) timeout();
      @(posedge sys_clk);
      if (wr) begin
         ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
      end else begin
         expq.push_back({m, ref_mem[a]});
      end
      @(negedge sys_clk);
      req.valid = 1'b0;
   endtask
   always @(posedge sys_clk) begin
      logic [31:0] e;
      if (rdata_valid === 1'b1) begin
         if (expq.size() == 0) begin
            chk("unexpected read", 32'h0, 32'h1);
         end else begin
            e = expq.pop_front();
            chk("read data", {e[31:16], e[15:0] & e[31:16]}, {e[31:16], rdata & e[31:16]});
         end
      end
   end
   initial begin
      int n, p, c, k;
      logic [9:0] row, col;
      void'($urandom(53985));
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      for (n = 0; n < 4000 && init_done !== 1'b1; n++) @(negedge sys_clk);
      if (n == 4000) timeout();
      chk("wake refreshes", 32'd8, cbr_cnt);
      for (p = 0; p < 4; p++) begin
         row = 10'($urandom);
         col = 10'($urandom);
         for (c = 0; c < 4; c++) addrs[4*p+c] = {row, col + 10'(c)};
         for (c = 0; c < 4; c++) access(1'b1, 2'b11, addrs[4*p+c], 16'($urandom), c == 3);
         for (c = 0; c < 4; c++) access(1'b0, 2'($urandom_range(1, 3)), addrs[4*p+c], 16'h0000, c == 3);
      end
      repeat (40) begin
         k = $urandom_range(0, 15);
         access(1'($urandom), 2'($urandom_range(1, 3)), addrs[k], 16'($urandom), 1'b1);
      end
      @(negedge sys_clk);
      self_req = 1'b1;
      for (n = 0; n < 1000 && in_self !== 1'b1; n++) @(negedge sys_clk);
      if (n == 1000) timeout();
      repeat (60) @(negedge sys_clk);
      self_req = 1'b0;
      for (n = 0; n < 1000 && in_self !== 1'b0; n++) @(negedge sys_clk);
      if (n == 1000) timeout();
      for (k = 0; k < 16; k++) access(1'b0, 2'b11, addrs[k], 16'h0000, 1'b1);
      for (n = 0; n < 200 && expq.size() != 0; n++) @(negedge sys_clk);
      if (n == 200) timeout();
      chk("refresh gap bound", 32'h1, max_gap_ns <= (REFI + 64) * 40);
      chk("self refresh low time", 32'h1, self_low_ns >= SELF * 40);
      chk("protocol faults", 32'h0, bad_cnt);
      finish_test();
   end
endmodule // byte_lane_page_mode_dram_tb

/* shared/blpmd_pkg.sv */
// Contract
// - hold write strobe high at refresh
// - twenty-bit address sent as row, column
// - release data pins while device drives
// - page mode: row once, toggle columns
// - every row refreshed within refresh period
// - self refresh: hold row strobe low
// - distributed refresh one row per 125us
// - exit self refresh: row strobe high trc
// - after self refresh, distributed needs no burst
// - self refresh row strobe low 100us
// - one column strobe suffices for refresh
// - power-up 100us wait, eight refreshes
package blpmd_pkg;
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned CLK_NS = 40;
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned TRC_NS = 130;
   localparam int unsigned TRP_NS = 50;
   localparam int unsigned TRAS_NS = 70;
   localparam int unsigned TCAS_NS = 20;
   localparam int unsigned TCP_NS = 10;
   localparam int unsigned TRCD_NS = 20;
   localparam int unsigned TWRP_NS = 10;
   localparam int unsigned TREFI_US = 125;
   localparam int unsigned TPWRUP_US = 100;
   localparam int unsigned SELF_REFRESH_ENTRY_TIME_US = 100;
   localparam int unsigned WAKE_CYCLES = 8;
   localparam int unsigned TRP_CYC = (TRC_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TRAS_CYC = (TRAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TCAS_CYC = (TCAS_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned TREFI_CYC = TREFI_US * CLK_MHZ;
   localparam int unsigned TPWRUP_CYC = TPWRUP_US * CLK_MHZ;
   localparam int unsigned SELF_REFRESH_ENTRY_TIME_CYC = (SELF_REFRESH_ENTRY_TIME_US + 1) * CLK_MHZ;
   localparam logic [3:0] WAKE_CNT = 4'h8;

   typedef enum {
      BLPMD_INIT, BLPMD_IDLE, BLPMD_ROW, BLPMD_COL, BLPMD_CASUP, BLPMD_PRE,
      BLPMD_CBR_CAS, BLPMD_CBR_RAS, BLPMD_SELF
   } blpmd_state_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] byte_en;
      logic [19:0] addr;
      logic [15:0] wdata;
      logic last;
   } blpmd_req_type;

   typedef struct packed {
      logic row_n;
      logic col_lo_n;
      logic col_hi_n;
      logic write_n;
      logic oe_n;
      logic [9:0] addr;
      logic [15:0] dq_out;
      logic [1:0] dq_oe;
   } blpmd_pins_type;
endpackage

/* src/blpmd_ctrl.sv */
`timescale 1ns/1ns
module blpmd_ctrl #(
   parameter int unsigned REFI_CYC = blpmd_pkg::TREFI_CYC,
   parameter int unsigned PWRUP_CYC = blpmd_pkg::TPWRUP_CYC,
   parameter int unsigned SELF_CYC = blpmd_pkg::SELF_REFRESH_ENTRY_TIME_CYC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire blpmd_pkg::blpmd_req_type req,
   output logic req_ready,
   output logic [15:0] rdata,
   output logic rdata_valid,
   input wire logic self_req,
   output logic in_self,
   output logic init_done,
   output blpmd_pkg::blpmd_pins_type pins,
   input wire logic [15:0] dq_in
);
   typedef struct packed {
      blpmd_pkg::blpmd_state_type st;
      logic [22:0] tmr;
      logic [22:0] refi;
      logic [3:0] wake;
      logic ref_due;
      logic open;
      logic [9:0] open_row;
      logic wr;
      logic [1:0] be;
      logic [9:0] col;
      logic last;
      logic [15:0] rdata;
      logic rvalid;
      logic self;
      logic done;
      blpmd_pkg::blpmd_pins_type p;
   } blpmd_regs_type;

   blpmd_regs_type r, next_r;
   logic rst_a, rst_n;
   logic [15:0] dq_s1, dq_s2, dq_s3, dq_f;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_a <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_a <= 1'b1;
         rst_n <= rst_a;
      end
   end

   // a data bit is taken only once the second and third stages agree, so a bit caught while the
   // device output turns on is never latched as read data
   always_ff @(posedge sys_clk) begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_s3 <= dq_s2;
      dq_f <= (~(dq_s2 ^ dq_s3) & dq_s3) | ((dq_s2 ^ dq_s3) & dq_f);
   end

   wire can_take = (r.st == blpmd_pkg::BLPMD_IDLE && !r.ref_due && !self_req && r.done)
                || (r.st == blpmd_pkg::BLPMD_CASUP && r.tmr == 23'h0 && !r.last && !r.ref_due);
   wire same_row = r.open && (req.addr[19:10] == r.open_row);
   assign req_ready = can_take && (r.st == blpmd_pkg::BLPMD_IDLE || same_row);

   always_comb begin
      next_r = r;
      next_r.rvalid = 1'b0;
      if (r.tmr != 23'h0) begin
         next_r.tmr = r.tmr - 23'h1;
      end
      if (r.refi != 23'h0) begin
         next_r.refi = r.refi - 23'h1;
      end else begin
         next_r.refi = 23'(REFI_CYC);
         next_r.ref_due = 1'b1;
      end
      unique case (r.st)
         blpmd_pkg::BLPMD_INIT: begin
            if (r.tmr == 23'h0) begin
               next_r.wake = blpmd_pkg::WAKE_CNT;
               next_r.st = blpmd_pkg::BLPMD_PRE;
               next_r.ref_due = 1'b1;
            end
         end
         blpmd_pkg::BLPMD_IDLE: begin
            if (r.ref_due || r.wake != 4'h0) begin
               next_r.p.col_lo_n = 1'b0;
               next_r.p.col_hi_n = 1'b0;
               next_r.p.write_n = 1'b1;
               next_r.p.dq_oe = 2'b00;
               next_r.st = blpmd_pkg::BLPMD_CBR_CAS;
            end else if (self_req && r.done) begin
               next_r.self = 1'b1;
               next_r.p.col_lo_n = 1'b0;
               next_r.p.write_n = 1'b1;
               next_r.st = blpmd_pkg::BLPMD_CBR_CAS;
            end else if (req_ready && req.valid) begin
               next_r.p.addr = req.addr[19:10];
               next_r.p.row_n = 1'b0;
               next_r.open = 1'b1;
               next_r.open_row = req.addr[19:10];
               next_r.wr = req.write;
               next_r.be = req.byte_en;
               next_r.col = req.addr[9:0];
               next_r.last = req.last;
               next_r.p.dq_out = req.wdata;
               next_r.tmr = 23'(blpmd_pkg::TRCD_CYC);
               next_r.st = blpmd_pkg::BLPMD_ROW;
            end
         end
         blpmd_pkg::BLPMD_ROW: begin
            next_r.p.addr = r.col;
            if (r.tmr == 23'h0) begin
               next_r.p.write_n = !r.wr;
               next_r.p.oe_n = r.wr;
               next_r.p.dq_oe = r.wr ? r.be : 2'b00;
               next_r.p.col_lo_n = !r.be[0];
               next_r.p.col_hi_n = !r.be[1];
               // strobe stays low until valid data has crossed all three sampling stages
               next_r.tmr = 23'(blpmd_pkg::TCAS_CYC + 3);
               next_r.st = blpmd_pkg::BLPMD_COL;
            end
         end
         blpmd_pkg::BLPMD_COL: begin
            if (r.tmr == 23'h0) begin
               if (!r.wr) begin
                  next_r.rdata = dq_f;
                  next_r.rvalid = 1'b1;
               end
               next_r.p.col_lo_n = 1'b1;
               next_r.p.col_hi_n = 1'b1;
               next_r.p.oe_n = 1'b1;
               next_r.p.write_n = 1'b1;
               next_r.p.dq_oe = 2'b00;
               next_r.tmr = 23'(blpmd_pkg::TCAS_CYC);
               next_r.st = blpmd_pkg::BLPMD_CASUP;
            end
         end
         blpmd_pkg::BLPMD_CASUP: begin
            if (r.tmr == 23'h0) begin
               if (req_ready && req.valid) begin
                  next_r.wr = req.write;
                  next_r.be = req.byte_en;
                  next_r.col = req.addr[9:0];
                  next_r.last = req.last;
                  next_r.p.dq_out = req.wdata;
                  // column goes out a cycle ahead of the strobe, as on the first access
                  next_r.p.addr = req.addr[9:0];
                  next_r.st = blpmd_pkg::BLPMD_ROW;
               end else begin
                  next_r.p.row_n = 1'b1;
                  next_r.open = 1'b0;
                  next_r.tmr = 23'(blpmd_pkg::TRP_CYC);
                  next_r.st = blpmd_pkg::BLPMD_PRE;
               end
            end
         end
         blpmd_pkg::BLPMD_PRE: begin
            if (r.tmr == 23'h0) begin
               next_r.st = blpmd_pkg::BLPMD_IDLE;
               if (r.wake == 4'h0 && r.self == 1'b0) begin
                  next_r.done = 1'b1;
               end
            end
         end
         blpmd_pkg::BLPMD_CBR_CAS: begin
            next_r.p.row_n = 1'b0;
            next_r.tmr = r.self ? 23'(SELF_CYC) : 23'(blpmd_pkg::TRAS_CYC);
            next_r.st = r.self ? blpmd_pkg::BLPMD_SELF : blpmd_pkg::BLPMD_CBR_RAS;
            if (!r.self) begin
               // an interval tick landing in this very cycle must not be lost
               next_r.ref_due = (r.refi == 23'h0);
               if (r.wake != 4'h0) begin
                  next_r.wake = r.wake - 4'h1;
               end
            end
         end
         blpmd_pkg::BLPMD_CBR_RAS: begin
            if (r.tmr == 23'h0) begin
               next_r.p.row_n = 1'b1;
               next_r.p.col_lo_n = 1'b1;
               next_r.p.col_hi_n = 1'b1;
               next_r.tmr = 23'(blpmd_pkg::TRP_CYC);
               next_r.st = blpmd_pkg::BLPMD_PRE;
            end
         end
         blpmd_pkg::BLPMD_SELF: begin
            // refresh timer held at its reload value; device refreshes itself
            next_r.ref_due = 1'b0;
            next_r.refi = 23'(REFI_CYC);
            if (r.tmr == 23'h0 && !self_req) begin
               next_r.p.row_n = 1'b1;
               next_r.p.col_lo_n = 1'b1;
               next_r.self = 1'b0;
               next_r.tmr = 23'(blpmd_pkg::TRP_CYC);
               next_r.st = blpmd_pkg::BLPMD_PRE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '{st: blpmd_pkg::BLPMD_INIT, tmr: 23'(PWRUP_CYC), refi: 23'(REFI_CYC), wake: 4'h0,
                ref_due: 1'b0, open: 1'b0, open_row: 10'h000, wr: 1'b0, be: 2'h0, col: 10'h000,
                last: 1'b0, rdata: 16'h0000, rvalid: 1'b0, self: 1'b0, done: 1'b0,
                p: '{row_n: 1'b1, col_lo_n: 1'b1, col_hi_n: 1'b1, write_n: 1'b1, oe_n: 1'b1,
                     addr: 10'h000, dq_out: 16'h0000, dq_oe: 2'h0}};
      end else begin
         r <= next_r;
      end
   end

   assign pins = r.p;
   assign rdata = r.rdata;
   assign rdata_valid = r.rvalid;
   assign in_self = r.st == blpmd_pkg::BLPMD_SELF;
   assign init_done = r.done;

   // four cycles of 40 ns cover the slower grade's exit precharge
   sequence blpmd_row_rest;
      r.p.row_n [*4];
   endsequence

   a_bus_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !r.p.oe_n |-> r.p.dq_oe == 2'b00) else $error("data driven while read enabled");
   a_cbr_write_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.st == blpmd_pkg::BLPMD_CBR_CAS) |=> r.p.write_n && !r.p.row_n) else $error("refresh write strobe");
   a_strobe_lanes: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.st == blpmd_pkg::BLPMD_COL) |-> ({!r.p.col_hi_n, !r.p.col_lo_n} == r.be)) else $error("lane mismatch");
   a_init_wait: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.st == blpmd_pkg::BLPMD_INIT) |-> r.p.row_n) else $error("row strobe before wait");
   a_page_row_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (r.st == blpmd_pkg::BLPMD_CASUP && req_ready && req.valid)
         |=> (!r.p.row_n && r.st == blpmd_pkg::BLPMD_ROW))
      else $error("page continuation dropped the row strobe");
   a_row_rest_time: assert property (@(posedge sys_clk) disable iff (!rst_n)
      $rose(r.p.row_n) |-> blpmd_row_rest) else $error("row strobe high too briefly");
endmodule // blpmd_ctrl
